// File: rtl/adcr_host.sv
/*
 * Host end of the chain: starts a conversion, optionally waits for busy,
 * clocks out 16*N (+1) bits, passes words through a two-entry buffer.
 * Assumes the user side drains words with valid/ready.
 */
module adcr_host #(
	parameter int unsigned WIDTH   = adcr_pkg::WORD_BITS,
	parameter int unsigned CHAIN_N = 2
) (
	input  wire logic             clk,
	input  wire logic             rst,
	adcr_link_if.host             link,
	input  wire logic             startReq,
	input  wire logic             useBusy,
	output logic                  startReady,
	output logic [WIDTH-1:0]      wordData,
	output logic                  wordValid,
	input  wire logic             wordReady
);
	adcr_pkg::adcr_host_state_t stateQ;
	logic [1:0]  sdoSyncQ;
	logic [15:0] cntQ, bitsQ;
	logic [WIDTH-1:0] accQ;
	logic [4:0]  bitInWordQ;
	logic        cnvQ, sckQ, busyQ, skipQ;
	logic [WIDTH-1:0] bufQ [2];
	logic        wPtrQ, rPtrQ;
	logic [1:0]  countQ;

	localparam logic [15:0] TOTAL = 16'(WIDTH * CHAIN_N);
	wire serial_out      = sdoSyncQ[1];
	wire bufFull  = (countQ == 2'h2);
	wire pushW    = (stateQ == adcr_pkg::HST_SHIFT_HI) && (cntQ == 16'(adcr_pkg::SCK_HALF - 1))
			&& !skipQ && (bitInWordQ == 5'(WIDTH - 1));
	wire popW     = wordValid & wordReady;
	wire halfDone = (cntQ == 16'(adcr_pkg::SCK_HALF - 1));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) sdoSyncQ <= 2'h0;
		else     sdoSyncQ <= {sdoSyncQ[0], link.serialOutEn ? link.serialOut : 1'b1};
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stateQ <= adcr_pkg::HST_IDLE;
			cntQ <= 16'h0000; bitsQ <= 16'h0000; bitInWordQ <= 5'h00;
			accQ <= '0; cnvQ <= 1'h0; sckQ <= 1'h0; busyQ <= 1'h0; skipQ <= 1'h0;
		end else begin
			cntQ <= halfDone ? 16'h0000 : cntQ + 16'h0001;
			case (stateQ)
				adcr_pkg::HST_IDLE: begin
					cntQ <= 16'h0000;
					if (startReq) begin
						// clock level at start selects busy mode
						sckQ   <= useBusy;
						busyQ  <= useBusy;
						stateQ <= adcr_pkg::HST_CONVERT;
					end
				end
				adcr_pkg::HST_CONVERT: begin
					cnvQ <= 1'h1;
					if (halfDone) begin
						sckQ   <= 1'h0;
						stateQ <= adcr_pkg::HST_WAIT_BUSY;
					end
				end
				adcr_pkg::HST_WAIT_BUSY: begin
					cntQ <= 16'h0000;
					// fixed wait without busy; rising output with it
					if (busyQ ? serial_out : (bitsQ == 16'(adcr_pkg::CONV_CYCLES * 2))) begin
						bitsQ  <= 16'h0000;
						// high first, so every sample coincides with a falling edge
						sckQ   <= 1'h1;
						skipQ  <= busyQ;
						stateQ <= adcr_pkg::HST_SHIFT_HI;
					end else begin
						bitsQ <= bitsQ + 16'h0001;
					end
				end
				adcr_pkg::HST_SHIFT_HI: begin
					if (halfDone && !bufFull) begin
						sckQ   <= 1'h0;
						stateQ <= adcr_pkg::HST_SHIFT_LO;
						if (!skipQ) begin
							accQ       <= {accQ[WIDTH-2:0], serial_out};
							bitInWordQ <= (bitInWordQ == 5'(WIDTH - 1)) ? 5'h00 : bitInWordQ + 5'h01;
							bitsQ      <= bitsQ + 16'h0001;
						end
						skipQ <= 1'h0;
					end else if (halfDone) begin
						cntQ <= cntQ;
					end
				end
				adcr_pkg::HST_SHIFT_LO: begin
					if (halfDone) begin
						if (bitsQ == TOTAL) begin
							stateQ <= adcr_pkg::HST_DONE;
						end else begin
							sckQ   <= 1'h1;
							stateQ <= adcr_pkg::HST_SHIFT_HI;
						end
					end
				end
				adcr_pkg::HST_DONE: begin
					cnvQ <= 1'h0;
					bitsQ <= 16'h0000;
					stateQ <= adcr_pkg::HST_IDLE;
				end
				default: stateQ <= adcr_pkg::HST_IDLE;
			endcase
		end
	end

	// two-entry buffer; full stalls the serial clock so no word is lost
	wire [WIDTH-1:0] pushData = {accQ[WIDTH-2:0], serial_out};
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bufQ[0] <= '0; bufQ[1] <= '0;
			wPtrQ <= 1'h0; rPtrQ <= 1'h0; countQ <= 2'h0;
		end else begin
			if (pushW && !bufFull) begin
				bufQ[wPtrQ] <= pushData;
				wPtrQ       <= ~wPtrQ;
			end
			if (popW) rPtrQ <= ~rPtrQ;
			countQ <= countQ + {1'b0, pushW && !bufFull} - {1'b0, popW};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wordData <= '0; wordValid <= 1'h0; startReady <= 1'h0;
		end else begin
			wordValid  <= (countQ != 2'h0) && !(popW && countQ == 2'h1);
			wordData   <= popW ? bufQ[~rPtrQ] : bufQ[rPtrQ];
			startReady <= (stateQ == adcr_pkg::HST_IDLE) && !startReq;
		end
	end

	assign link.convertStart = cnvQ;
	assign link.serialClk    = sckQ;
	assign link.fastMode     = 1'b0;
endmodule

// File: pkg/adcr_pkg.sv
/*
 * Shared constants and types for the daisy-chained converter readout:
 * word width, conversion time, host serial clock divider.
 * Assumes a 125 MHz system clock on both ends.
 */
package adcr_pkg;
	localparam int unsigned CLK_PERIOD_NS  = 8;
	localparam int unsigned WORD_BITS      = 16;
	// conversion time in ns, and its cycle count rounded up
	localparam int unsigned CONV_TIME_NS   = 400;
	localparam int unsigned CONV_CYCLES    = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// host serial clock half period in system cycles
	localparam int unsigned SCK_HALF       = 8;
	localparam logic [15:0] RESULT_RESET   = 16'h0000;
	localparam int unsigned SYNC_STAGES    = 2;

	typedef enum logic [1:0] {
		DEV_IDLE,
		DEV_CONVERT,
		DEV_READ
	} adcr_dev_state_t;

	typedef enum logic [2:0] {
		HST_IDLE,
		HST_CONVERT,
		HST_WAIT_BUSY,
		HST_SHIFT_LO,
		HST_SHIFT_HI,
		HST_DONE
	} adcr_host_state_t;
endpackage

// File: pkg/adcr_link_if.sv
/*
 * Four-wire chain link between the host and the converter nearest it.
 * Assumes the host and the testbench resolve serialOut from its enable (pull-up if idle).
 */
interface adcr_link_if;
	logic convertStart;
	logic serialClk;
	logic fastMode;
	logic serialOut;
	logic serialOutEn;

	modport device (
		input  convertStart,
		input  serialClk,
		input  fastMode,
		output serialOut,
		output serialOutEn
	);
	modport host (
		output convertStart,
		output serialClk,
		output fastMode,
		input  serialOut,
		input  serialOutEn
	);
endinterface

// File: rtl/adcr_device.sv
/*
 * Converter end of the chain: conversion timing, result shift register,
 * chain input pass-through, busy indicator.
 * Assumes link pins are asynchronous to clk; the sample value comes from
 * a user-side port standing in for the analog core.
 */
// Behaviour
// - chain modes only with fast mode low
// - chain in and start low drive output low
// - clock low at start: chain, no busy
// - clock high at start: chain with busy
// - host holds start high through readback
// - no busy: MSB out at conversion end
// - remaining bits out on clock falling edges
// - chain input shifted in on falling edge
// - host gives sixteen clocks per converter
// - busy variant: nearest converter drives output high
// - host starts readback on output rise
// - busy variant: sixteen N plus one clocks
// - output stable across both clock edges
// - busy variant: acquire and power down after
// - host samples on falling clock edge
// - conversion completes regardless of start input
module adcr_device #(
	parameter int unsigned WIDTH = adcr_pkg::WORD_BITS
) (
	input  wire logic             clk,
	input  wire logic             rst,
	adcr_link_if.device           link,
	input  wire logic             chainSerialIn,
	input  wire logic [WIDTH-1:0] sampleValue,
	output logic                  convDone,
	output logic                  poweredDown,
	output logic                  fastModeFault
);
	adcr_pkg::adcr_dev_state_t stateQ, stateD;

	logic [1:0] cnvSyncQ, sckSyncQ, sdiSyncQ, fastSyncQ;
	logic       cnvPrevQ, sckPrevQ;
	logic [WIDTH-1:0] shiftQ;
	logic [15:0] convCntQ;
	logic       busyModeQ, outQ, outEnQ;
	logic       busyPhaseQ;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnvSyncQ  <= 2'h0;
			sckSyncQ  <= 2'h0;
			sdiSyncQ  <= 2'h0;
			fastSyncQ <= 2'h0;
			cnvPrevQ  <= 1'h0;
			sckPrevQ  <= 1'h0;
		end else begin
			cnvSyncQ  <= {cnvSyncQ[0], link.convertStart};
			sckSyncQ  <= {sckSyncQ[0], link.serialClk};
			sdiSyncQ  <= {sdiSyncQ[0], chainSerialIn};
			fastSyncQ <= {fastSyncQ[0], link.fastMode};
			cnvPrevQ  <= cnvSyncQ[1];
			sckPrevQ  <= sckSyncQ[1];
		end
	end

	wire convert_start      = cnvSyncQ[1];
	wire sck      = sckSyncQ[1];
	wire chain_serial_in      = sdiSyncQ[1];
	wire cnvRise  = convert_start & ~cnvPrevQ;
	wire sckFall  = ~sck & sckPrevQ;
	// chain modes refused while fast mode is selected
	wire startOk  = cnvRise & ~fastSyncQ[1];
	wire convEnd  = (stateQ == adcr_pkg::DEV_CONVERT) &&
			(convCntQ == 16'(adcr_pkg::CONV_CYCLES - 1));
	// busy: wait until upstream output (chain in) shows high, i.e. all done
	wire busyFire = busyPhaseQ & chain_serial_in;

	always_comb begin
		stateD = stateQ;
		case (stateQ)
			adcr_pkg::DEV_IDLE:    if (startOk) stateD = adcr_pkg::DEV_CONVERT;
			adcr_pkg::DEV_CONVERT: if (convEnd) stateD = adcr_pkg::DEV_READ;
			adcr_pkg::DEV_READ:    if (!convert_start) stateD = adcr_pkg::DEV_IDLE;
			default:               stateD = adcr_pkg::DEV_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stateQ   <= adcr_pkg::DEV_IDLE;
			convCntQ <= 16'h0000;
		end else begin
			stateQ   <= stateD;
			convCntQ <= (stateQ == adcr_pkg::DEV_CONVERT) ? convCntQ + 16'h0001 : 16'h0000;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busyModeQ <= 1'h0;
		end else if (startOk && stateQ == adcr_pkg::DEV_IDLE) begin
			busyModeQ <= sck;
		end
	end

	// shift register: load at end, then chain in on falling edges
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shiftQ <= adcr_pkg::RESULT_RESET;
		end else if (convEnd) begin
			shiftQ <= sampleValue;
		end else if (stateQ == adcr_pkg::DEV_READ && !busyPhaseQ && sckFall) begin
			shiftQ <= {shiftQ[WIDTH-2:0], chain_serial_in};
		end
	end

	// busy variant: hold output low until the chain reports done, then
	// high; the following falling edge starts the data out
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busyPhaseQ <= 1'h0;
		end else if (convEnd) begin
			busyPhaseQ <= busyModeQ;
		end else if (busyPhaseQ && outQ && sckFall) begin
			busyPhaseQ <= 1'h0;
		end else if (stateQ != adcr_pkg::DEV_READ) begin
			busyPhaseQ <= 1'h0;
		end
	end

	wire outD = (stateQ == adcr_pkg::DEV_READ) ?
			(busyPhaseQ ? (outQ | busyFire) : shiftQ[WIDTH-1]) : 1'b0;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			outQ          <= 1'h0;
			outEnQ        <= 1'h0;
			convDone      <= 1'h0;
			poweredDown   <= 1'h0;
			fastModeFault <= 1'h0;
		end else begin
			// changes after a falling edge, at conversion end or on busy-done, so stable over rising
			outQ          <= outD;
			// driven low while converting, so a pull-up never fakes busy-done
			outEnQ        <= (stateQ != adcr_pkg::DEV_IDLE) | (~chain_serial_in & ~convert_start);
			convDone      <= convEnd;
			poweredDown   <= (stateQ == adcr_pkg::DEV_READ);
			fastModeFault <= cnvRise & fastSyncQ[1];
		end
	end

	assign link.serialOut   = outQ;
	assign link.serialOutEn = outEnQ;
endmodule

// File: tb/adcr_asserts.sv
/* link checker: timing properties of the host-facing chain link.
   assumes the host clock domain and a two-converter chain. */
module adcr_asserts #(
	parameter int unsigned CHAIN_N = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic convertStart,
	input wire logic serialClk,
	input wire logic fastMode,
	input wire logic serialOut,
	input wire logic serialOutEn
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] falls_q;
	logic       busy_q;
	// falls counted per frame; busy mode latched at the start edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			falls_q <= 8'h00;
			busy_q  <= 1'b0;
		end else if ($rose(convertStart)) begin
			falls_q <= 8'h00;
			busy_q  <= serialClk;
		end else if ($fell(serialClk) && $past(convertStart, 16)) begin
			// mode-select fall early in the conversion is not a read clock
			falls_q <= falls_q + 8'h01;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_fast_mode_low: assert property (!fastMode)
		else $error("fast mode raised");
	a_idle_drive_low: assert property (!convertStart && $past(convertStart, 4) == 1'b0
		&& serialOutEn |-> !serialOut) else $error("idle output not low");
	a_no_busy_read: assert property ($rose(convertStart) && !serialClk
		|-> ##[50:62] serialOutEn) else $error("no result after conversion");
	a_busy_flag_high: assert property ($rose(convertStart) && serialClk
		|-> ##[50:70] (serialOutEn && serialOut)) else $error("busy done missing");
	a_conv_quiet: assert property ($rose(convertStart)
		|-> ##8 (!serialOut && $stable(serialClk)) [*8]) else $error("early output");
	a_hold_after_fall: assert property ($fell(serialClk) |=> $stable(serialOut))
		else $error("output moved at fall");
	a_stable_at_rise: assert property ($rose(serialClk) |-> $stable(serialOut))
		else $error("output moved at rise");
	a_frame_clocks: assert property ($fell(convertStart)
		|-> falls_q == 8'(busy_q ? 16 * CHAIN_N + 1 : 16 * CHAIN_N))
		else $error("wrong clock count");
endmodule

// File: tb/test_adc_daisy_chain_readout.sv
/* bench: host and two chained converters, plus a lone converter
   driven directly for fault cases. assumes the shared link interface. */
module test_adc_daisy_chain_readout;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk;
	logic        rst;
	logic        startReq;
	logic        useBusy;
	logic        startReady;
	logic [15:0] wordData;
	logic        wordValid;
	logic        wordReady;
	logic [15:0] sampleNear;
	logic [15:0] sampleFar;
	logic        pdNear;
	logic        badIn;
	logic        badDone;
	logic        badFault;
	wire         farLine;
	int          nFail = 0;
	int          checked = 0;
	adcr_link_if link();
	adcr_link_if linkFar();
	adcr_link_if linkBad();
	assign linkFar.convertStart = link.convertStart;
	assign linkFar.serialClk    = link.serialClk;
	assign linkFar.fastMode     = link.fastMode;
	// pulled-up chain line between the two converters
	assign farLine = linkFar.serialOutEn ? linkFar.serialOut : 1'b1;
	adcr_host #(.CHAIN_N(2)) i_adcr_host (.clk(clk), .rst(rst), .link(link),
		.startReq(startReq), .useBusy(useBusy), .startReady(startReady),
		.wordData(wordData), .wordValid(wordValid), .wordReady(wordReady));
	adcr_device i_adcr_device (.clk(clk), .rst(rst), .link(link), .chainSerialIn(farLine),
		.sampleValue(sampleNear), .convDone(), .poweredDown(pdNear), .fastModeFault());
	adcr_device i_adcr_device_far (.clk(clk), .rst(rst), .link(linkFar), .chainSerialIn(1'b1),
		.sampleValue(sampleFar), .convDone(), .poweredDown(), .fastModeFault());
	adcr_device i_adcr_device_bad (.clk(clk), .rst(rst), .link(linkBad), .chainSerialIn(badIn),
		.sampleValue(sampleFar), .convDone(badDone), .poweredDown(), .fastModeFault(badFault));
	adcr_asserts #(.CHAIN_N(2)) i_adcr_asserts (.clk(clk), .rst(rst),
		.convertStart(link.convertStart), .serialClk(link.serialClk),
		.fastMode(link.fastMode), .serialOut(link.serialOut), .serialOutEn(link.serialOutEn));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic close_out();
		$display("checked %0d, failed %0d", checked, nFail);
		if (nFail == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			nFail++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wait_hi(ref logic sig);
		int n;
		n = 0;
		while (sig !== 1'b1 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		if (n == 5000) begin
			nFail++;
			$display("Error at %0t: wait timed out", $time);
			close_out();
		end
	endtask
	// one frame; user side stalls long enough for the buffer to fill
	task automatic readback(input logic busy, input logic [15:0] far, input logic [15:0] near);
		sampleFar = far;
		sampleNear = near;
		useBusy = busy;
		wait_hi(startReady);
		startReq = 1'b1;
		@(negedge clk);
		startReq = 1'b0;
		wait_hi(wordValid);
		check({15'h0000, pdNear}, 16'h0001);
		repeat (600) @(negedge clk);
		wordReady = 1'b1;
		check(wordData, near);
		@(negedge clk);
		wait_hi(wordValid);
		check(wordData, far);
		@(negedge clk);
		wordReady = 1'b0;
	endtask
	initial begin
		int n;
		rst = 1'b1;
		{startReq, useBusy, wordReady, badIn} = 4'h0;
		{sampleNear, sampleFar} = 32'h0000_0000;
		{linkBad.convertStart, linkBad.serialClk, linkBad.fastMode} = 3'h0;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		readback(1'b0, 16'ha5c3, 16'h3c5a);
		readback(1'b1, 16'h8001, 16'h7ffe);
		repeat (8) @(negedge clk);
		check({14'h0000, linkBad.serialOutEn, linkBad.serialOut}, 16'h0002);
		badIn = 1'b1;
		linkBad.fastMode = 1'b1;
		linkBad.convertStart = 1'b1;
		wait_hi(badFault);
		n = 0;
		repeat (80) begin
			@(negedge clk);
			if (badDone !== 1'b0) n++;
		end
		check(16'(n), 16'h0000);
		linkBad.convertStart = 1'b0;
		linkBad.fastMode = 1'b0;
		repeat (8) @(negedge clk);
		linkBad.convertStart = 1'b1;
		repeat (10) @(negedge clk);
		// start dropped mid-conversion, result still due
		linkBad.convertStart = 1'b0;
		wait_hi(badDone);
		close_out();
	end
endmodule
